// ---- include/flash_seq_cfg.svh ----
// Constants for the flash command sequencer and its bus master
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH
// ============================================================
// Command addresses and data
`define UNLOCK1_ADDR     12'h555
`define UNLOCK2_ADDR     12'hAAA
`define UNLOCK1_DATA     8'hAA
`define UNLOCK2_DATA     8'h55
`define CMD_RESET_READ   8'hF0
`define CMD_PROGRAM      8'hA0
`define CMD_ERASE_SETUP  8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_BULK_ERASE   8'h10
`define CMD_READ_ID      8'h90
// ============================================================
// Register select (reads while in ID mode)
`define REG_PRI_PROT_ADDR 12'h002
`define REG_SEC_PROT_ADDR 12'h004
`define REG_ID_ADDR       12'h000
// ============================================================
// Status bit positions
`define ERROR_FLAG_BIT 5
`define SECURITY_BIT   7
// ============================================================
// Timing
`define RECOVER_NS  25000
`define CLK_NS      40
`define RECOVER_CYC ((`RECOVER_NS) / (`CLK_NS))
`define PROGRAM_CYC 64
`define ERASE_CYC   512
`endif

// ---- include/flash_seq_pkg.sv ----
// Types shared by the flash sequencer ends
package flash_seq_pkg;
	typedef enum logic [1:0] {OP_NONE, OP_PROGRAM, OP_SECTOR_ERASE, OP_BULK_ERASE} op_t;
	typedef logic [11:0] addr_t;
	typedef logic [7:0]  data_t;
endpackage

// ---- include/flash_bus_if.sv ----
// Memory bus between the microcontroller master and the flash sequencer
`timescale 1ns/1ns
interface flash_bus_if;
	logic [1:0]  area;
	logic [2:0]  sector;
	logic [11:0] addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic        ready_busy_pin;
	modport dev  (input area, sector, addr, wdata, wr, rd, output rdata, ready_busy_pin);
	modport host (output area, sector, addr, wdata, wr, rd, input rdata, ready_busy_pin);
endinterface

// ---- hw/flash_seq_dev.sv ----
// Flash command sequencer with reset-to-read and sector protection
`timescale 1ns/1ns
`include "flash_seq_cfg.svh"
// Functional notes
// - Decode multi-write command sequences into algorithms
// - Reset command single write or after unlock
// - Master resets after reading ID or protection
// - Failure sets error flag bit five
// - Error reset returns read within 25us
// - Reset ignored during program or bulk erase
// - Reset aborts sector erase within 25us
// - Reset pin aborts cycle, returns read
// - Reset during cycle: read within 25us
// - Master holds reset at least 25us
// - Primary protect register: bit per sector
// - Secondary protect bits 3:0, security bit 7
// - Ready/busy low while program or erase runs
// - Primary array: eight protectable sectors
// - Secondary array: four protectable sectors
module flash_seq_dev
	import flash_seq_pkg::*;
#(
	parameter int PRI_SECTORS = 8,
	parameter int SEC_SECTORS = 4,
	parameter int RECOVER_CYC = `RECOVER_CYC
)(
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// Protection configuration
	input  wire logic [7:0]           pri_protect,
	input  wire logic [3:0]           sec_protect,
	input  wire logic                 security_set,
	// Array access (failure injected by the array model)
	input  wire logic                 array_fail,
	output      logic                 array_we_ff,
	output      logic                 array_erase_ff,
	output      logic                 read_mode_ff,
	// Bus
	flash_bus_if.dev                  bus
);
	import flash_seq_pkg::*;

	initial begin
		if (PRI_SECTORS != 8 || SEC_SECTORS != 4 || RECOVER_CYC < 1)
			$error("flash_seq_dev: unsupported parameters");
	end

	typedef enum logic [3:0] {S_READ, S_UNL1, S_UNL2, S_CMD, S_ERS1, S_ERS2, S_ERS3,
		S_PGM_DATA, S_BUSY, S_ERROR, S_RECOVER, S_ID} state_t;

	// ============================================================
	// State
	state_t         state_ff, nxt_state;
	op_t            op_ff, nxt_op;
	logic [15:0]    cnt_ff, nxt_cnt;
	logic [7:0]     rdata_ff, nxt_rdata;
	logic           rb_ff, nxt_rb;
	logic           we_n, er_n, rm_n;
	logic           prot;
	logic           is_reset_cmd;

	// Protection of the addressed sector, primary or secondary
	always_comb
	begin
		prot = (bus.area == 2'd0) ? pri_protect[bus.sector]
			: sec_protect[bus.sector[1:0]];
	end

	assign is_reset_cmd = bus.wr && bus.wdata == `CMD_RESET_READ;

	// ============================================================
	// Next state
	always_comb
	begin
		nxt_state = state_ff;
		nxt_op    = op_ff;
		nxt_cnt   = cnt_ff;
		nxt_rdata = rdata_ff;
		we_n      = 1'b0;
		er_n      = 1'b0;
		case (state_ff)
			S_READ, S_ID:
			begin
				if (is_reset_cmd)
					nxt_state = S_READ;
				else if (bus.wr && bus.addr == `UNLOCK1_ADDR && bus.wdata == `UNLOCK1_DATA)
					nxt_state = S_UNL1;
			end
			S_UNL1:
			begin
				if (bus.wr)
					nxt_state = (bus.addr == `UNLOCK2_ADDR && bus.wdata == `UNLOCK2_DATA)
						? S_CMD : S_READ;
			end
			S_CMD:
			begin
				if (bus.wr)
				begin
					case (bus.wdata)
						`CMD_PROGRAM:     nxt_state = S_PGM_DATA;
						`CMD_ERASE_SETUP: nxt_state = S_ERS1;
						`CMD_READ_ID:     nxt_state = S_ID;
						default:          nxt_state = S_READ;
					endcase
				end
			end
			S_PGM_DATA:
			begin
				if (bus.wr)
				begin
					if (prot)
						nxt_state = S_READ;
					else
					begin
						nxt_state = S_BUSY;
						nxt_op    = OP_PROGRAM;
						nxt_cnt   = 16'(`PROGRAM_CYC);
					end
				end
			end
			S_ERS1:
			begin
				if (bus.wr)
					nxt_state = (bus.wdata == `UNLOCK1_DATA) ? S_ERS2 : S_READ;
			end
			S_ERS2:
			begin
				if (bus.wr)
					nxt_state = (bus.wdata == `UNLOCK2_DATA) ? S_ERS3 : S_READ;
			end
			S_ERS3:
			begin
				if (bus.wr)
				begin
					nxt_state = S_READ;
					nxt_cnt   = 16'(`ERASE_CYC);
					if (bus.wdata == `CMD_SECTOR_ERASE && !prot)
					begin
						nxt_state = S_BUSY;
						nxt_op    = OP_SECTOR_ERASE;
					end
					else if (bus.wdata == `CMD_BULK_ERASE && pri_protect == 8'h00
						&& sec_protect == 4'h0)
					begin
						nxt_state = S_BUSY;
						nxt_op    = OP_BULK_ERASE;
					end
				end
			end
			S_BUSY:
			begin
				we_n = (op_ff == OP_PROGRAM);
				er_n = (op_ff != OP_PROGRAM);
				nxt_cnt = cnt_ff - 16'h0001;
				if (is_reset_cmd && op_ff == OP_SECTOR_ERASE)
				begin
					nxt_state = S_RECOVER;
					nxt_cnt   = 16'(RECOVER_CYC);
				end
				else if (array_fail)
				begin
					nxt_state = S_ERROR;
					nxt_rdata = 8'h00 | (8'h01 << `ERROR_FLAG_BIT);
				end
				else if (cnt_ff == 16'h0001)
				begin
					nxt_state = S_READ;
					nxt_op    = OP_NONE;
				end
				// Reset command during program or bulk erase falls through
			end
			S_ERROR:
			begin
				if (is_reset_cmd)
				begin
					nxt_state = S_RECOVER;
					nxt_cnt   = 16'(RECOVER_CYC);
				end
			end
			S_RECOVER:
			begin
				nxt_cnt = cnt_ff - 16'h0001;
				if (cnt_ff <= 16'h0001)
				begin
					// Back in read mode: the error flag bit is dropped with it
					nxt_state = S_READ;
					nxt_op    = OP_NONE;
					nxt_rdata = 8'h00;
				end
			end
			default: nxt_state = S_READ;
		endcase
		if (state_ff == S_ID && bus.rd)
		begin
			case (bus.addr)
				`REG_PRI_PROT_ADDR: nxt_rdata = pri_protect;
				`REG_SEC_PROT_ADDR: nxt_rdata = {security_set, 3'b000, sec_protect};
				default:            nxt_rdata = 8'h00;
			endcase
		end
		nxt_rb = !(nxt_state == S_BUSY || nxt_state == S_ERROR || nxt_state == S_RECOVER);
		rm_n   = (nxt_state != S_BUSY && nxt_state != S_ERROR && nxt_state != S_RECOVER
			&& nxt_state != S_ID);
	end

	// ============================================================
	// Registers; reset pin aborts any cycle and returns to read
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff       <= S_READ;
			op_ff          <= OP_NONE;
			cnt_ff         <= 16'h0000;
			rdata_ff       <= 8'h00;
			rb_ff          <= 1'b1;
			array_we_ff    <= 1'b0;
			array_erase_ff <= 1'b0;
			read_mode_ff   <= 1'b1;
		end
		else
		begin
			state_ff       <= nxt_state;
			op_ff          <= nxt_op;
			cnt_ff         <= nxt_cnt;
			rdata_ff       <= nxt_rdata;
			rb_ff          <= nxt_rb;
			array_we_ff    <= we_n;
			array_erase_ff <= er_n;
			read_mode_ff   <= rm_n;
		end
	end

	assign bus.rdata          = rdata_ff;
	assign bus.ready_busy_pin = rb_ff;

endmodule // flash_seq_dev

// ---- hw/flash_seq_host.sv ----
// Bus master end: issues flash commands on request
`timescale 1ns/1ns
`include "flash_seq_cfg.svh"
module flash_seq_host
	import flash_seq_pkg::*;
#(
	parameter int RESET_HOLD_CYC = `RECOVER_CYC
)(
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// User requests
	input  wire logic                 req,
	input  wire flash_seq_pkg::op_t   req_op,
	input  wire logic                 req_reset,
	input  wire logic [1:0]           req_area,
	input  wire logic [2:0]           req_sector,
	input  wire logic [7:0]           req_data,
	output      logic                 done_ff,
	output      logic                 error_ff,
	output      logic                 busy_ff,
	// Bus
	flash_bus_if.host                 bus
);
	import flash_seq_pkg::*;

	initial begin
		if (RESET_HOLD_CYC < 1)
			$error("flash_seq_host: bad reset hold");
	end

	logic [2:0] step_ff, nxt_step;
	logic [2:0] len_ff,  nxt_len;
	logic       act_ff,  nxt_act;
	logic       rs_ff,   nxt_rs;
	logic [11:0] a;
	logic [7:0]  d;

	// ============================================================
	// Write sequence per step
	always_comb
	begin
		a = `UNLOCK1_ADDR;
		d = `UNLOCK1_DATA;
		case (step_ff)
			3'd0: begin a = `UNLOCK1_ADDR; d = `UNLOCK1_DATA; end
			3'd1: begin a = `UNLOCK2_ADDR; d = `UNLOCK2_DATA; end
			3'd2: begin a = `UNLOCK1_ADDR; d = rs_ff ? `CMD_RESET_READ
				: (len_ff == 3'd4 ? `CMD_PROGRAM : `CMD_ERASE_SETUP); end
			3'd3: begin a = `UNLOCK1_ADDR; d = (len_ff == 3'd4) ? req_data : `UNLOCK1_DATA; end
			3'd4: begin a = `UNLOCK2_ADDR; d = `UNLOCK2_DATA; end
			3'd5: begin a = 12'h000; d = (len_ff == 3'd6) ? `CMD_SECTOR_ERASE : `CMD_BULK_ERASE; end
			default: begin a = 12'h000; d = 8'h00; end
		endcase
		nxt_step = step_ff;
		nxt_len  = len_ff;
		nxt_act  = act_ff;
		nxt_rs   = rs_ff;
		if (!act_ff && req)
		begin
			nxt_act  = 1'b1;
			nxt_step = 3'd0;
			nxt_rs   = req_reset;  // reset after ID or error
			nxt_len  = req_reset ? 3'd3 : (req_op == OP_PROGRAM ? 3'd4
				: (req_op == OP_SECTOR_ERASE ? 3'd6 : 3'd7));
		end
		else if (act_ff)
		begin
			nxt_step = step_ff + 3'd1;
			if (step_ff + 3'd1 == len_ff || (len_ff == 3'd7 && step_ff == 3'd5))
				nxt_act = 1'b0;
		end
	end

	// ============================================================
	// Registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			step_ff   <= 3'd0;
			len_ff    <= 3'd0;
			act_ff    <= 1'b0;
			rs_ff     <= 1'b0;
			done_ff   <= 1'b0;
			error_ff  <= 1'b0;
			busy_ff   <= 1'b0;
			bus.wr    <= 1'b0;
			bus.rd    <= 1'b0;
			bus.addr  <= 12'h000;
			bus.wdata <= 8'h00;
			bus.area  <= 2'd0;
			bus.sector <= 3'd0;
		end
		else
		begin
			step_ff   <= nxt_step;
			len_ff    <= nxt_len;
			act_ff    <= nxt_act;
			rs_ff     <= nxt_rs;
			done_ff   <= act_ff && !nxt_act;
			error_ff  <= bus.rdata[`ERROR_FLAG_BIT];
			busy_ff   <= !bus.ready_busy_pin;
			bus.wr    <= act_ff;
			bus.rd    <= 1'b0;
			bus.addr  <= a;
			bus.wdata <= d;
			bus.area  <= req_area;
			bus.sector <= req_sector;
		end
	end
	// RESET_HOLD_CYC documents the minimum reset pulse the system applies

endmodule // flash_seq_host

// ---- tb/flash_bus_sva.sv ----
// Assertions on the bus between the flash master and sequencer
`timescale 1ns/1ns
`include "flash_seq_cfg.svh"
module flash_bus_sva (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// Bus
	input wire logic [11:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic [7:0]  rdata,
	input wire logic        ready_busy_pin
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ============================================================
	// Command steps
	sequence unlock1; wr && addr == `UNLOCK1_ADDR && wdata == `UNLOCK1_DATA; endsequence
	sequence unlock2; wr && addr == `UNLOCK2_ADDR && wdata == `UNLOCK2_DATA; endsequence
	sequence unlock; unlock1 ##1 unlock2; endsequence
	sequence cmd(logic [7:0] c); wr && addr == `UNLOCK1_ADDR && wdata == c; endsequence
	// ============================================================
	// Properties
	AST_RST_READY: assert property ($rose(rst_n) |-> ready_busy_pin && rdata == 8'h00)
		else $error("bus not idle after reset");
	AST_UNLOCK_PAIR: assert property (unlock1 |=> unlock2)
		else $error("first unlock write not followed by second");
	AST_UNLOCK_NEXT: assert property (unlock |=> wr && wdata inside {`CMD_PROGRAM, `CMD_ERASE_SETUP,
		`CMD_RESET_READ, `CMD_READ_ID, `CMD_SECTOR_ERASE, `CMD_BULK_ERASE})
		else $error("unlock not followed by a command");
	AST_PGM_DATA: assert property (unlock ##1 cmd(`CMD_PROGRAM) |=> wr)
		else $error("program command without data write");
	AST_ERASE_SEQ: assert property (unlock ##1 cmd(`CMD_ERASE_SETUP) |=> unlock ##1
		(wr && (wdata == `CMD_SECTOR_ERASE || wdata == `CMD_BULK_ERASE)))
		else $error("erase setup not completed");
	AST_BUSY_CAUSE: assert property ($fell(ready_busy_pin) |-> $past(wr) || $past(wr, 2))
		else $error("busy without a command write");
	AST_BUSY_HOLD: assert property ($fell(ready_busy_pin) |=> !ready_busy_pin)
		else $error("busy pulse too short");
	AST_RESET_QUIET: assert property (ready_busy_pin && wr && wdata == `CMD_RESET_READ
		|=> ready_busy_pin [*2])
		else $error("reset command started a cycle");
endmodule // flash_bus_sva

// ---- tb/tb_top.sv ----
// Self-checking bench for the flash master and sequencer pair
`timescale 1ns/1ns
`include "flash_seq_cfg.svh"
module tb_top;
	import flash_seq_pkg::*;
	localparam int REC = 4;
	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] pri_protect = 8'h00;
	logic [3:0] sec_protect = 4'h0;
	logic       security_set = 1'b0;
	logic       array_fail = 1'b0;
	logic       req = 1'b0;
	op_t        req_op = OP_NONE;
	logic       req_reset = 1'b0;
	logic [1:0] req_area = 2'h0;
	logic [2:0] req_sector = 3'h0;
	logic [7:0] req_data = 8'h00;
	logic       array_we_ff, array_erase_ff, read_mode_ff, done_ff, error_ff, busy_ff;
	int         error_cnt = 0;
	int         checks = 0;
	int         cyc = 0;
	int         exp_q[$];
	int         n;
	flash_bus_if bus ();
	flash_seq_dev #(.RECOVER_CYC(REC)) flash_seq_dev_inst (.clk_sys, .rst_n, .pri_protect,
		.sec_protect, .security_set, .array_fail, .array_we_ff, .array_erase_ff, .read_mode_ff,
		.bus(bus));
	flash_seq_host #(.RESET_HOLD_CYC(REC)) flash_seq_host_inst (.clk_sys, .rst_n, .req, .req_op,
		.req_reset, .req_area, .req_sector, .req_data, .done_ff, .error_ff, .busy_ff, .bus(bus));
	flash_bus_sva flash_bus_sva_inst (.clk_sys, .rst_n, .addr(bus.addr), .wdata(bus.wdata),
		.wr(bus.wr), .rdata(bus.rdata), .ready_busy_pin(bus.ready_busy_pin));
	// ============================================================
	// Clock and timeout
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			wrap_up();
		end
	end
	// ============================================================
	// Tasks
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask
	task automatic issue(input op_t op, input logic rs, input logic [1:0] ar, input logic [2:0] sc);
		int k;
		req = 1'b1;
		req_op = op;
		req_reset = rs;
		req_area = ar;
		req_sector = sc;
		// Data below A0h never equals the AAh first unlock byte or the F0h reset byte
		req_data = 8'($urandom % 32'hA0);
		step(1);
		req = 1'b0;
		k = 0;
		while (done_ff !== 1'b1 && k < 40)
		begin
			step(1);
			k++;
		end
		check(k < 40, "no done");
		step(2);
	endtask
	task automatic busy_len(output int len);
		len = 0;
		while (busy_ff === 1'b1 && len < 3000)
		begin
			step(1);
			len++;
		end
	endtask
	task automatic wrap_up();
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ============================================================
	// Scenarios
	initial
	begin
		int e;
		logic p;
		op_t op;
		logic [1:0] ar;
		logic [2:0] sc;
		void'($urandom(23));
		repeat (6) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		step(1);
		for (int i = 0; i < 8; i++)
		begin
			op = op_t'(1 + i % 3);
			pri_protect = (i < 3) ? 8'h00 : 8'($urandom);
			sec_protect = 4'($urandom);
			security_set = 1'($urandom);
			ar = (op == OP_BULK_ERASE) ? 2'h0 : 2'($urandom % 2);
			sc = (ar == 2'h0) ? 3'($urandom) : 3'($urandom % 4);
			p = (op == OP_BULK_ERASE) ? (|pri_protect || |sec_protect)
				: (ar == 2'h0) ? pri_protect[sc] : sec_protect[sc[1:0]];
			exp_q.push_back(p ? 0 : (op == OP_PROGRAM) ? `PROGRAM_CYC : `ERASE_CYC);
			issue(op, 1'b0, ar, sc);
			busy_len(n);
			e = exp_q.pop_front();
			check(e == 0 ? n == 0 : (n >= e - 6 && n <= e + 2), "busy length");
		end
		pri_protect = 8'h00;
		sec_protect = 4'h0;
		issue(OP_SECTOR_ERASE, 1'b0, 2'h0, 3'h3);
		step(10);
		issue(OP_NONE, 1'b1, 2'h0, 3'h0);
		busy_len(n);
		check(n <= REC + 8 && read_mode_ff === 1'b1, "erase not aborted");
		issue(OP_BULK_ERASE, 1'b0, 2'h0, 3'h0);
		step(10);
		issue(OP_NONE, 1'b1, 2'h0, 3'h0);
		busy_len(n);
		check(n >= `ERASE_CYC - 40, "bulk erase cut short");
		array_fail = 1'b1;
		issue(OP_PROGRAM, 1'b0, 2'h0, 3'h1);
		step(5);
		check(error_ff === 1'b1 && busy_ff === 1'b1, "error flag missing");
		array_fail = 1'b0;
		issue(OP_NONE, 1'b1, 2'h0, 3'h0);
		busy_len(n);
		check(n <= REC + 8 && error_ff === 1'b0 && read_mode_ff === 1'b1, "no recovery");
		issue(OP_SECTOR_ERASE, 1'b0, 2'h1, 3'h2);
		step(10);
		rst_n = 1'b0;
		step(6);
		rst_n = 1'b1;
		step(1);
		check(read_mode_ff === 1'b1 && busy_ff === 1'b0 && array_erase_ff === 1'b0, "reset");
		wrap_up();
	end
endmodule // tb_top
